// file: logic/fpc_pkg.sv
// constants, types and field layouts of the flash program and protect controller
// Function
// - software loads timing reload with clock MHz minus one before any modification
// - two protection bits per 2-KB block, kept in pairs of 32-bit registers
// - cleared program enable refuses program and erase of that block
// - cleared read enable allows instruction fetch only, no data reads
// - data read of a read-protected block is blocked with a bus fault
// - protected program or erase sets raw access flag; mask gates interrupt
// - every protection bit defaults to one, open access
// - uncommitted configuration survives all resets except power-on reset
// - raw programming flag sets when program or erase completes
// - raw flags always readable; masked status and interrupt follow the mask
// - writing one to the clear register clears raw and masked flag
// - flash accesses stall while program or erase runs
// - word program: data, address, then write command; write bit clears at end
// - page erase: address, then erase command; erase bit clears at end
// - mass erase command; mass erase bit clears once the array is erased
// - commit command commits the selected configuration word; commit bit polls busy
// - commit codes zero to three select read/program enable words from themselves
// - commit codes 8000_0000 to 8000_0003 select user words from their own contents
// - configuration words ignore erases and bits only go from one to zero
// - user and debug words commit once, flagged by bit 31; protection repeatedly
// - erase sets block bits to one, programming only clears bits
package fpc_pkg;
  localparam int ADDR_W = 12;
  localparam int FADDR_W = 17;
  localparam int BLK_LSB = 11;
  localparam int PAGE_LSB = 10;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [11:0] OFF_ADDR = 12'h000;
  localparam logic [11:0] OFF_DATA = 12'h004;
  localparam logic [11:0] OFF_CMD = 12'h008;
  localparam logic [11:0] OFF_RAW = 12'h00c;
  localparam logic [11:0] OFF_MASK = 12'h010;
  localparam logic [11:0] OFF_CLR = 12'h014;
  localparam logic [11:0] OFF_RE0 = 12'h130;
  localparam logic [11:0] OFF_PE0 = 12'h134;
  localparam logic [11:0] OFF_RELOAD = 12'h140;
  localparam logic [11:0] OFF_DBG = 12'h1d0;
  localparam logic [11:0] OFF_USER0 = 12'h1e0;
  localparam logic [11:0] OFF_RE0_ALT = 12'h200;
  localparam logic [11:0] OFF_RE1 = 12'h204;
  localparam logic [11:0] OFF_PE0_ALT = 12'h400;
  localparam logic [11:0] OFF_PE1 = 12'h404;
  // ****************************************************
  // fields, codes and reset values
  // ****************************************************
  localparam logic [15:0] WRITE_KEY = 16'ha442;
  localparam int CMD_WRITE = 0;
  localparam int CMD_ERASE = 1;
  localparam int CMD_MASS = 2;
  localparam int CMD_COMMIT = 3;
  localparam int IRQ_ACCESS = 0;
  localparam int IRQ_PROG = 1;
  localparam int NW_BIT = 31;
  localparam logic [31:0] DBG_CODE = 32'h7510_0000;
  localparam logic [29:0] USER_CODE_HI = 30'h2000_0000;
  localparam logic [31:0] PROT_RST = 32'hffff_ffff;
  localparam logic [31:0] USER_RST = 32'hffff_ffff;
  localparam logic [31:0] DBG_RST = 32'hffff_fffe;
  localparam logic [7:0] RELOAD_RST = 8'h18;
  // operation times in microseconds
  localparam int PROG_US = 20;
  localparam int ERASE_US = 20000;
  localparam int MASS_US = 200000;
  localparam int COMMIT_US = 20;
  // commit selectors seen by the array
  localparam logic [3:0] SEL_USER0 = 4'h4;
  localparam logic [3:0] SEL_DBG = 4'h8;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} fpc_state_t;

  typedef struct packed {
    logic [1:0][31:0] re;
    logic [1:0][31:0] pe;
    logic [3:0][31:0] user;
    logic [31:0] dbg;
  } fpc_nv_t;

  typedef struct packed {
    logic busy;
    logic prog;
    logic page_erase;
    logic mass_erase;
    logic [FADDR_W-1:0] addr;
    logic [31:0] data;
  } fpc_array_t;

  typedef struct packed {
    logic valid;
    logic [3:0] sel;
    logic [31:0] data;
  } fpc_commit_t;
endpackage

// file: logic/fpc_top.sv
// flash program, erase, commit and protection controller
`timescale 1ns/1ps
module fpc_top
  import fpc_pkg::*;
#(
  parameter int PROG_TIME_US = PROG_US,
  parameter int ERASE_TIME_US = ERASE_US,
  parameter int MASS_TIME_US = MASS_US,
  parameter int COMMIT_TIME_US = COMMIT_US
) (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // system reset
  input wire logic por_n, // power-on reset
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic rq_valid, // processor flash read request
  input wire logic [FADDR_W-1:0] rq_addr, // flash read address
  input wire logic rq_fetch, // request is an instruction fetch
  output logic rq_stall, // request held off
  output logic rq_fault, // bus fault for request
  output logic arr_rd_en, // read passed to array
  output fpc_array_t arr_op, // operation to array
  output fpc_commit_t nv_commit, // commit pulse to array
  input fpc_nv_t nv_committed, // committed words from array
  output logic irq // controller interrupt
);
  // ****************************************************
  // state
  // ****************************************************
  fpc_state_t state_reg, state_next;
  fpc_nv_t nv_reg, nv_next;
  logic [31:0] addr_reg;
  logic [31:0] data_reg;
  logic [3:0] cmd_reg;
  logic [1:0] raw_reg;
  logic [1:0] mask_reg;
  logic [7:0] reload_reg;
  logic [7:0] tick_reg;
  logic [17:0] us_reg;
  logic restore_reg;
  logic [3:0] csel_reg;
  logic [31:0] cdata_reg;
  logic [31:0] rdata_reg;
  fpc_array_t arr_reg;
  fpc_commit_t commit_reg;

  // system reset leaves the configuration words alone
  wire rst_n = arst_n & por_n;

  // ****************************************************
  // decode
  // ****************************************************
  wire hit_addr = reg_addr == OFF_ADDR;
  wire hit_data = reg_addr == OFF_DATA;
  wire hit_cmd = reg_addr == OFF_CMD;
  wire hit_raw = reg_addr == OFF_RAW;
  wire hit_mask = reg_addr == OFF_MASK;
  wire hit_clr = reg_addr == OFF_CLR;
  wire hit_reload = reg_addr == OFF_RELOAD;
  wire hit_dbg = reg_addr == OFF_DBG;
  wire hit_re0 = (reg_addr == OFF_RE0) || (reg_addr == OFF_RE0_ALT);
  wire hit_pe0 = (reg_addr == OFF_PE0) || (reg_addr == OFF_PE0_ALT);
  wire hit_re1 = reg_addr == OFF_RE1;
  wire hit_pe1 = reg_addr == OFF_PE1;
  wire hit_user = (reg_addr[ADDR_W-1:4] == OFF_USER0[ADDR_W-1:4]);
  wire [1:0] user_idx = reg_addr[3:2];

  wire busy = state_reg == ST_RUN;
  wire [1:0] masked = raw_reg & mask_reg;

  // ****************************************************
  // command acceptance and protection check
  // ****************************************************
  wire key_ok = reg_wdata[31:16] == WRITE_KEY;
  wire cmd_wr = reg_wr && hit_cmd && key_ok && !busy;
  wire [63:0] pe_bits = {nv_reg.pe[1], nv_reg.pe[0]};
  wire [63:0] re_bits = {nv_reg.re[1], nv_reg.re[0]};
  wire [5:0] op_blk = addr_reg[FADDR_W-1:BLK_LSB];
  wire blk_pe_ok = pe_bits[op_blk];
  // mass erase would touch every block, so any locked block refuses it
  wire all_pe_ok = &pe_bits;
  wire want_write = cmd_wr && reg_wdata[CMD_WRITE];
  wire want_erase = cmd_wr && !reg_wdata[CMD_WRITE] && reg_wdata[CMD_ERASE];
  wire want_mass = cmd_wr && reg_wdata[2:0] == 3'b100;
  wire want_commit = cmd_wr && reg_wdata[3:0] == 4'b1000;
  wire go_write = want_write && blk_pe_ok;
  wire go_erase = want_erase && blk_pe_ok;
  wire go_mass = want_mass && all_pe_ok;
  wire denied = (want_write || want_erase) && !blk_pe_ok || want_mass && !all_pe_ok;

  // commit target selection
  wire is_prot = addr_reg[31:2] == 30'h0;
  wire is_user = addr_reg[31:2] == USER_CODE_HI;
  wire is_dbg = addr_reg == DBG_CODE;
  wire [1:0] cidx = addr_reg[1:0];
  // codes 0..3 map read0, prog0, read1, prog1
  wire [31:0] prot_src = cidx[0] ? nv_reg.pe[cidx[1]] : nv_reg.re[cidx[1]];
  wire user_open = nv_reg.user[cidx][NW_BIT];
  wire dbg_open = nv_reg.dbg[NW_BIT];
  wire commit_ok = is_prot || is_user && user_open || is_dbg && dbg_open;
  wire go_commit = want_commit && commit_ok;
  wire [3:0] csel_next = is_prot ? {2'b00, cidx} :
                         is_user ? (SEL_USER0 | {2'b00, cidx}) : SEL_DBG;
  // committed user and debug words carry a cleared flag, so a power-on restore keeps them locked
  wire [31:0] nw_clear = ~(32'h1 << NW_BIT);
  wire [31:0] cdata_next = is_prot ? prot_src :
                           is_user ? (nv_reg.user[cidx] & nw_clear) :
                           (nv_reg.dbg & data_reg & nw_clear);
  wire go_any = go_write || go_erase || go_mass || go_commit;

  // ****************************************************
  // microsecond timebase and operation length
  // ****************************************************
  wire tick = tick_reg == 8'h00;
  wire [17:0] op_us = go_write ? 18'(PROG_TIME_US) :
                      go_erase ? 18'(ERASE_TIME_US) :
                      go_mass ? 18'(MASS_TIME_US) : 18'(COMMIT_TIME_US);
  wire op_end = busy && tick && (us_reg == 18'h00001);
  wire prog_done = op_end && !cmd_reg[CMD_COMMIT];
  wire commit_done = op_end && cmd_reg[CMD_COMMIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go_any) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (op_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************************
  // configuration words
  // ****************************************************
  always_comb begin
    nv_next = nv_reg;
    if (restore_reg) begin
      nv_next = nv_committed;
    end else begin
      if (reg_wr && hit_re0) begin
        nv_next.re[0] = nv_reg.re[0] & reg_wdata;
      end
      if (reg_wr && hit_pe0) begin
        nv_next.pe[0] = nv_reg.pe[0] & reg_wdata;
      end
      if (reg_wr && hit_re1) begin
        nv_next.re[1] = nv_reg.re[1] & reg_wdata;
      end
      if (reg_wr && hit_pe1) begin
        nv_next.pe[1] = nv_reg.pe[1] & reg_wdata;
      end
      if (reg_wr && hit_user && nv_reg.user[user_idx][NW_BIT]) begin
        nv_next.user[user_idx] = nv_reg.user[user_idx] & reg_wdata;
      end
      if (commit_done && csel_reg[3]) begin
        nv_next.dbg = cdata_reg & ~(32'h1 << NW_BIT);
      end else if (commit_done && csel_reg[2]) begin
        nv_next.user[csel_reg[1:0]][NW_BIT] = 1'b0;
      end
    end
  end

  // only power-on reset reloads these; a system reset keeps trial values
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      nv_reg <= {{2{PROT_RST}}, {2{PROT_RST}}, {4{USER_RST}}, DBG_RST};
      restore_reg <= 1'b1;
    end else begin
      nv_reg <= nv_next;
      restore_reg <= 1'b0;
    end
  end

  // ****************************************************
  // control registers
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      addr_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
      mask_reg <= 2'b00;
      reload_reg <= RELOAD_RST;
    end else begin
      state_reg <= state_next;
      if (reg_wr && hit_addr && !busy) begin
        addr_reg <= reg_wdata;
      end
      if (reg_wr && hit_data && !busy) begin
        data_reg <= reg_wdata;
      end
      if (reg_wr && hit_mask) begin
        mask_reg <= reg_wdata[1:0];
      end
      if (reg_wr && hit_reload) begin
        reload_reg <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= 4'h0;
      tick_reg <= 8'h00;
      us_reg <= 18'h00000;
      csel_reg <= 4'h0;
      cdata_reg <= 32'h0000_0000;
    end else if (go_any) begin
      cmd_reg <= {go_commit, go_mass, go_erase, go_write};
      tick_reg <= reload_reg;
      us_reg <= op_us;
      csel_reg <= csel_next;
      cdata_reg <= cdata_next;
    end else if (busy) begin
      tick_reg <= tick ? reload_reg : tick_reg - 8'h01;
      us_reg <= tick ? us_reg - 18'h00001 : us_reg;
      // command bit stays up for polling and drops as the operation ends
      cmd_reg <= op_end ? 4'h0 : cmd_reg;
    end
  end

  // ****************************************************
  // interrupt flags
  // ****************************************************
  // a new event in the clearing cycle wins over the clear
  wire [1:0] clr_bits = (reg_wr && hit_clr) ? reg_wdata[1:0] : 2'b00;
  wire [1:0] set_bits = {prog_done, denied};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_reg <= 2'b00;
    end else begin
      raw_reg <= (raw_reg & ~clr_bits) | set_bits;
    end
  end

  // ****************************************************
  // array and commit outputs
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_reg <= '0;
      commit_reg <= '0;
    end else begin
      commit_reg.valid <= commit_done;
      commit_reg.sel <= csel_reg;
      commit_reg.data <= cdata_reg;
      if (go_write || go_erase || go_mass) begin
        arr_reg.busy <= 1'b1;
        arr_reg.prog <= go_write;
        arr_reg.page_erase <= go_erase;
        arr_reg.mass_erase <= go_mass;
        // low address bits are dropped; misaligned requests are the caller's risk
        arr_reg.addr <= go_erase ? {addr_reg[FADDR_W-1:PAGE_LSB], 10'h000} :
                                   {addr_reg[FADDR_W-1:2], 2'b00};
        arr_reg.data <= data_reg;
      end else if (prog_done) begin
        arr_reg <= '0;
      end
    end
  end

  // ****************************************************
  // processor read path
  // ****************************************************
  wire [5:0] rq_blk = rq_addr[FADDR_W-1:BLK_LSB];
  assign rq_stall = rq_valid && arr_reg.busy;
  assign rq_fault = rq_valid && !rq_fetch && !re_bits[rq_blk];
  assign arr_rd_en = rq_valid && !arr_reg.busy && !rq_fault;
  assign arr_op = arr_reg;
  assign nv_commit = commit_reg;
  assign irq = |masked;

  // ****************************************************
  // register read
  // ****************************************************
  // the debug word is read only; it changes only through its commit
  wire [31:0] rd_mux = hit_addr ? addr_reg :
                       hit_data ? data_reg :
                       hit_cmd ? {28'h0, cmd_reg} :
                       hit_raw ? {30'h0, raw_reg} :
                       hit_mask ? {30'h0, mask_reg} :
                       hit_clr ? {30'h0, masked} :
                       hit_reload ? {24'h0, reload_reg} :
                       hit_dbg ? nv_reg.dbg :
                       hit_re0 ? nv_reg.re[0] :
                       hit_pe0 ? nv_reg.pe[0] :
                       hit_re1 ? nv_reg.re[1] :
                       hit_pe1 ? nv_reg.pe[1] :
                       hit_user ? nv_reg.user[user_idx] : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

// file: sim/fpc_assertions.sv
// concurrent checks on the flash controller ports
`timescale 1ns/1ps
module fpc_assertions
  import fpc_pkg::*;
#(
  parameter int PROG_TIME_US = PROG_US,
  parameter int ERASE_TIME_US = ERASE_US,
  parameter int MASS_TIME_US = MASS_US,
  parameter int COMMIT_TIME_US = COMMIT_US
) (
  input wire logic ref_clk, // clock
  input wire logic arst_n, // system reset
  input wire logic por_n, // power-on reset
  input wire logic [ADDR_W-1:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic rq_valid, // read request
  input wire logic [FADDR_W-1:0] rq_addr, // request address
  input wire logic rq_fetch, // fetch request
  input wire logic rq_stall, // stall
  input wire logic rq_fault, // fault
  input wire logic arr_rd_en, // array read
  input fpc_array_t arr_op, // array operation
  input fpc_commit_t nv_commit, // commit pulse
  input fpc_nv_t nv_committed, // committed words
  input wire logic irq // interrupt
);
  // longest legal operation: reload of 255 on the slowest kind
  localparam int BUSY_MAX = 256 * MASS_TIME_US + 2;
  int busy_cnt;
  always_ff @(posedge ref_clk or negedge arst_n or negedge por_n) begin
    if (!arst_n || !por_n) busy_cnt <= 0;
    else busy_cnt <= arr_op.busy ? busy_cnt + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !por_n);
  stall_match_a: assert property (
    rq_stall == (rq_valid && arr_op.busy)) else $error("stall differs from busy");
  fetch_open_a: assert property (
    rq_valid && rq_fetch |-> !rq_fault) else $error("fetch faulted");
  rd_gate_a: assert property (
    arr_rd_en == (rq_valid && !rq_stall && !rq_fault)) else $error("array read gate wrong");
  key_guard_a: assert property (
    reg_wr && reg_addr == OFF_CMD && reg_wdata[31:16] != WRITE_KEY && !arr_op.busy
    |=> !arr_op.busy) else $error("keyless command started");
  op_hold_a: assert property (
    arr_op.busy && $past(arr_op.busy) |-> $stable(arr_op.addr) && $stable(arr_op.data))
    else $error("operation fields moved");
  op_kind_a: assert property (
    arr_op.busy |-> $onehot({arr_op.prog, arr_op.page_erase, arr_op.mass_erase}))
    else $error("operation kind not single");
  op_idle_a: assert property (
    !arr_op.busy |-> arr_op == '0) else $error("idle operation not zero");
  erase_align_a: assert property (
    arr_op.page_erase |-> arr_op.addr[9:0] == 10'h0) else $error("erase page unaligned");
  commit_pulse_a: assert property (
    nv_commit.valid |=> !nv_commit.valid) else $error("commit pulse too long");
  clear_irq_a: assert property (
    reg_wr && reg_addr == OFF_CLR && reg_wdata[1:0] == 2'h3 && !arr_op.busy
    && !$past(reg_wr) |=> !irq) else $error("clear left interrupt up");
  op_bound_a: assert property (
    busy_cnt <= BUSY_MAX) else $error("operation overran");
  cover property (arr_op.prog);
  cover property (arr_op.mass_erase);
  cover property (nv_commit.valid && nv_commit.sel == SEL_DBG);
  cover property (rq_fault);
endmodule
bind fpc_top fpc_assertions #(.PROG_TIME_US(PROG_TIME_US), .ERASE_TIME_US(ERASE_TIME_US),
  .MASS_TIME_US(MASS_TIME_US), .COMMIT_TIME_US(COMMIT_TIME_US)) chk_u (.ref_clk(ref_clk),
  .arst_n(arst_n), .por_n(por_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rq_valid(rq_valid),
  .rq_addr(rq_addr), .rq_fetch(rq_fetch), .rq_stall(rq_stall), .rq_fault(rq_fault),
  .arr_rd_en(arr_rd_en), .arr_op(arr_op), .nv_commit(nv_commit),
  .nv_committed(nv_committed), .irq(irq));

// file: sim/fpc_flash_model.sv
// array stand-in that keeps committed configuration words
`timescale 1ns/1ps
module fpc_flash_model
  import fpc_pkg::*;
(
  input wire logic ref_clk, // clock
  input fpc_commit_t nv_commit, // commit pulse
  output fpc_nv_t nv_committed // retained words
);
  // no reset here: committed words outlive power-on reset
  fpc_nv_t nv_reg = {{8{32'hffff_ffff}}, DBG_RST};
  assign nv_committed = nv_reg;
  always @(posedge ref_clk) begin
    if (nv_commit.valid && nv_commit.sel == SEL_DBG) nv_reg.dbg <= nv_commit.data;
    else if (nv_commit.valid && nv_commit.sel[2])
      nv_reg.user[nv_commit.sel[1:0]] <= nv_commit.data;
    else if (nv_commit.valid && nv_commit.sel[0]) nv_reg.pe[nv_commit.sel[1]] <= nv_commit.data;
    else if (nv_commit.valid) nv_reg.re[nv_commit.sel[1]] <= nv_commit.data;
  end
endmodule

// file: sim/fpc_top_bench.sv
// self-checking bench for the flash controller
`timescale 1ns/1ps
module fpc_top_bench
  import fpc_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rq_valid = 1'b0, rq_fetch = 1'b0, rd_pend = 1'b0, rq_stall, rq_fault, arr_rd_en, irq;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [FADDR_W-1:0] rq_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, d, a, pe0, re0;
  logic [31:0] exp_q[$];
  fpc_array_t arr_op;
  fpc_commit_t nv_commit;
  fpc_nv_t nv_committed;
  int n_fail = 0, checks = 0, k;
  int tt[3] = '{2, 3, 4};
  always #5 ref_clk = ~ref_clk;
  fpc_top #(.PROG_TIME_US(2), .ERASE_TIME_US(3), .MASS_TIME_US(4), .COMMIT_TIME_US(2))
    dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .por_n(por_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rq_valid(rq_valid), .rq_addr(rq_addr), .rq_fetch(rq_fetch), .rq_stall(rq_stall),
    .rq_fault(rq_fault), .arr_rd_en(arr_rd_en), .arr_op(arr_op), .nv_commit(nv_commit),
    .nv_committed(nv_committed), .irq(irq));
  fpc_flash_model far_u (.ref_clk(ref_clk), .nv_commit(nv_commit), .nv_committed(nv_committed));
  task automatic chk_reg(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    chk_reg(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic tally_and_finish();
    repeat (2) @(posedge ref_clk);
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // strobes stay up between back-to-back accesses of one kind; wr and rd lower the other strobe, cyc and wait_for lower both
  task automatic wr(logic [11:0] ad, logic [31:0] dt);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [11:0] ad, logic [31:0] ex);
    reg_addr <= ad;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back(ex);
    @(posedge ref_clk);
  endtask
  task automatic cyc(int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  // 0 or 1: busy level, 2: commit pulse; outputs seen are those of the cycle just ended
  task automatic wait_for(int what, output int n);
    n = 0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    while (!((what == 2) ? nv_commit.valid === 1'b1 : arr_op.busy === what[0])) begin
      if (n == 1100) begin
        chk_bit("wait bound", 1'b0, 1'b1);
        tally_and_finish();
      end
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic commit(logic [31:0] code, logic [3:0] sel, logic [31:0] dt);
    wr(OFF_ADDR, code);
    wr(OFF_CMD, {WRITE_KEY, 16'h0008});
    rd(OFF_CMD, 32'h8);
    wait_for(2, k);
    chk_reg("commit sel", {28'h0, sel}, {28'h0, nv_commit.sel});
    chk_reg("commit data", dt, nv_commit.data);
    rd(OFF_CMD, 32'h0);
  endtask
  always @(posedge ref_clk) begin
    if (rd_pend) chk_reg("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_pend <= reg_rd;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    d = $urandom(32'he022);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    cyc(2);
    rd(OFF_RELOAD, 32'h18);
    rd(OFF_PE0, PROT_RST);
    rd(OFF_RE1, PROT_RST);
    rd(OFF_DBG, DBG_RST);
    rd(12'h0f0, 32'h0);
    wr(OFF_RELOAD, 32'h1);
    wr(OFF_MASK, 32'h3);
    rq_valid <= 1'b1;
    rq_fetch <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      a = {16'h0, 5'(i + 1), (i == 0) ? {9'($urandom), 2'b00} : 11'h0};
      rq_addr <= a[16:0];
      wr(OFF_DATA, d);
      wr(OFF_ADDR, a);
      wr(OFF_CMD, {WRITE_KEY, 16'(1 << i)});
      wait_for(1, k);
      chk_reg("op kind", 32'(1 << i),
              {29'h0, arr_op.mass_erase, arr_op.page_erase, arr_op.prog});
      if (i != 2) chk_reg("op addr", a, {15'h0, arr_op.addr});
      if (i == 0) chk_reg("op data", d, arr_op.data);
      chk_bit("stall", 1'b1, rq_stall);
      chk_bit("read held", 1'b0, arr_rd_en);
      wait_for(0, k);
      chk_bit("op length", 1'b1, k >= 2 * tt[i] - 1 && k <= 2 * tt[i] + 1);
      rd(OFF_CMD, 32'h0);
      rd(OFF_RAW, 32'h2);
      wr(OFF_CLR, 32'h0);
      rd(OFF_CLR, 32'h2);
      chk_bit("irq up", 1'b1, irq);
      wr(OFF_CLR, 32'h3);
      rd(OFF_RAW, 32'h0);
      chk_bit("irq down", 1'b0, irq);
    end
    wr(OFF_CMD, 32'h5a5a_0001);
    cyc(2);
    chk_bit("keyless", 1'b0, arr_op.busy);
    pe0 = ~32'h2;
    wr(OFF_PE0, pe0);
    rd(OFF_PE0_ALT, pe0);
    wr(OFF_ADDR, 32'h0000_0800);
    wr(OFF_CMD, {WRITE_KEY, 16'h0002});
    cyc(2);
    chk_bit("refused", 1'b0, arr_op.busy);
    rd(OFF_RAW, 32'h1);
    chk_bit("access irq", 1'b1, irq);
    wr(OFF_MASK, 32'h2);
    rd(OFF_CLR, 32'h0);
    chk_bit("masked irq", 1'b0, irq);
    wr(OFF_CLR, 32'h3);
    wr(OFF_PE0, 32'hffff_fff0);
    pe0 = pe0 & 32'hffff_fff0;
    rd(OFF_PE0, pe0);
    re0 = ~32'h4;
    wr(OFF_RE0, re0);
    rq_addr <= 17'h1000;
    rq_fetch <= 1'b0;
    cyc(2);
    chk_bit("data fault", 1'b1, rq_fault);
    chk_bit("data passed", 1'b0, arr_rd_en);
    rq_fetch <= 1'b1;
    cyc(2);
    chk_bit("fetch fault", 1'b0, rq_fault);
    chk_bit("fetch passed", 1'b1, arr_rd_en);
    commit(32'h0000_0001, 4'h1, pe0);
    commit(32'h8000_0000, SEL_USER0, 32'h7fff_ffff);
    rd(OFF_USER0, 32'h7fff_ffff);
    wr(OFF_USER0, 32'h0);
    rd(OFF_USER0, 32'h7fff_ffff);
    wr(OFF_ADDR, 32'h8000_0000);
    wr(OFF_CMD, {WRITE_KEY, 16'h0008});
    rd(OFF_CMD, 32'h0);
    d = $urandom;
    wr(OFF_DATA, d);
    commit(DBG_CODE, SEL_DBG, DBG_RST & d & 32'h7fff_ffff);
    rd(OFF_DBG, DBG_RST & d & 32'h7fff_ffff);
    cyc(2);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(2);
    rd(OFF_RE0, re0);
    rd(OFF_RELOAD, 32'h18);
    cyc(2);
    por_n <= 1'b0;
    cyc(2);
    por_n <= 1'b1;
    cyc(2);
    rd(OFF_RE0, PROT_RST);
    rd(OFF_PE0, pe0);
    rd(OFF_USER0, 32'h7fff_ffff);
    tally_and_finish();
  end
endmodule
